// ### nvc_defines.svh
/*
  Constants for the nvSRAM store/recall host controller: sequence addresses,
  pin widths and timing counts at a 50 MHz clock.
  Assumes inclusion by bare name from the package and the modules.
*/
`ifndef NVC_DEFINES_SVH
`define NVC_DEFINES_SVH

`define NVC_ADDR_W 13
`define NVC_DATA_W 8
`define NVC_CLK_NS 20
// -------------------------------------------------
// software sequence addresses
// -------------------------------------------------
`define NVC_SEQ_A0 13'h0000
`define NVC_SEQ_A1 13'h1555
`define NVC_SEQ_A2 13'h0AAA
`define NVC_SEQ_A3 13'h1FFF
`define NVC_SEQ_A4 13'h10F0
`define NVC_SEQ_STORE 13'h0F0F
`define NVC_SEQ_RECALL 13'h0F0E
// -------------------------------------------------
// timing (ns) and derived counts
// -------------------------------------------------
`define NVC_CYC_NS 100
`define NVC_CYC_CNT ((`NVC_CYC_NS + `NVC_CLK_NS - 1) / `NVC_CLK_NS)
`define NVC_CNT_W 20
`endif

// ### nvc_pkg.sv
/*
  Types for the nvSRAM store/recall host controller.
  Assumes nvc_defines.svh is on the include path.
*/
`include "nvc_defines.svh"
package nvc_pkg;
  typedef enum logic [1:0] {
    NVC_CMD_READ,
    NVC_CMD_WRITE,
    NVC_CMD_SW_STORE,
    NVC_CMD_SW_RECALL
  } nvc_cmd_t;

  typedef struct packed {
    logic chipEnableN;
    logic writeEnableN;
    logic outputEnableN;
    logic [`NVC_ADDR_W-1:0] addr;
  } nvc_bus_t;
endpackage

// ### nvc_timer.sv
/*
  Down counter used to wait out busy and delay intervals.
  Assumes a single clock domain; load takes priority over counting.
*/
`timescale 1ns/1ns
`include "nvc_defines.svh"
module nvc_timer
  import nvc_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic load,
  input wire logic [`NVC_CNT_W-1:0] loadValue,
  output logic done
);
  logic [`NVC_CNT_W-1:0] count_q;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= '0;
    end else if (load) begin
      count_q <= loadValue;
    end else if (count_q != '0) begin
      count_q <= count_q - `NVC_CNT_W'(1);
    end
  end

  // done must not look at load: load is built from done outside
  assign done = (count_q == '0);
endmodule

// ### nvc_host_ctrl.sv
/*
  Host controller for an 8K x 8 nonvolatile SRAM: plain reads and writes,
  software store/recall sequences, hardware store via the request/busy line.
  Assumes device pins are synchronous to clock; the request/busy line is
  open drain, combined outside from busyOe_n.
*/
// Notes on behaviour
// - after hardware store, host releases request/busy before further access.
// - software store is six CE reads ending at address 0F0F.
// - software recall uses the same prefix ending at address 0F0E.
// - host builds sequences only from read cycles, chip-enable clocked.
// - host keeps write and chip enable inactive at end of power-up recall.
`timescale 1ns/1ns
`include "nvc_defines.svh"
module nvc_host_ctrl
  import nvc_pkg::*;
#(
  parameter int STORE_NS = 10000000,
  parameter int RECALL_NS = 20000,
  parameter int POWERUP_RECALL_NS = 40000000,
  parameter int DELAY_NS = 1000
)(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic reqValid,
  input nvc_cmd_t reqCmd,
  input wire logic [`NVC_ADDR_W-1:0] reqAddr,
  input wire logic [`NVC_DATA_W-1:0] reqWData,
  input wire logic hwStoreReq,
  output logic reqReady,
  output logic rspValid,
  output logic [`NVC_DATA_W-1:0] rspRData,
  output nvc_bus_t memBus,
  output logic [`NVC_DATA_W-1:0] dqOut,
  output logic dqOe_n,
  input wire logic [`NVC_DATA_W-1:0] dqIn,
  output logic busyOe_n,
  input wire logic storeRequestBusyLine
);
  // -------------------------------------------------
  // timing counts (cycles, rounded up: these are waits)
  // -------------------------------------------------
  localparam int STORE_CYC = (STORE_NS + `NVC_CLK_NS - 1) / `NVC_CLK_NS;
  localparam int RECALL_CYC = (RECALL_NS + `NVC_CLK_NS - 1) / `NVC_CLK_NS;
  localparam int PUR_CYC = (POWERUP_RECALL_NS + `NVC_CLK_NS - 1) / `NVC_CLK_NS;
  localparam int DELAY_CYC = (DELAY_NS + `NVC_CLK_NS - 1) / `NVC_CLK_NS;

  typedef enum logic [3:0] {
    S_POWERUP, S_IDLE, S_CYCLE, S_GAP, S_SEQ, S_WAIT_NV,
    S_HW_DELAY, S_HW_BUSY, S_HW_RELEASE
  } nvc_state_t;

  nvc_state_t state_q;
  nvc_bus_t bus_q;
  logic [2:0] seqIdx_q;
  logic isWrite_q;
  logic isRecall_q;
  logic [`NVC_DATA_W-1:0] wData_q;
  logic reqReady_q;
  logic rspValid_q;
  logic [`NVC_DATA_W-1:0] rspRData_q;
  logic dqOe_n_q;
  logic busyOe_n_q;
  logic tLoad;
  logic [`NVC_CNT_W-1:0] tValue;
  logic tDone;

  // -------------------------------------------------
  // sequence address selection
  // -------------------------------------------------
  wire logic [`NVC_ADDR_W-1:0] seqAddr =
    (seqIdx_q == 3'h0) ? `NVC_SEQ_A0 :
    (seqIdx_q == 3'h1) ? `NVC_SEQ_A1 :
    (seqIdx_q == 3'h2) ? `NVC_SEQ_A2 :
    (seqIdx_q == 3'h3) ? `NVC_SEQ_A3 :
    (seqIdx_q == 3'h4) ? `NVC_SEQ_A4 :
    (isRecall_q ? `NVC_SEQ_RECALL : `NVC_SEQ_STORE);
  wire logic lineLow = !storeRequestBusyLine;
  wire logic takeReq = (state_q == S_IDLE) && reqValid && !lineLow;
  wire logic isSeqCmd = (reqCmd == NVC_CMD_SW_STORE) || (reqCmd == NVC_CMD_SW_RECALL);
  wire logic lastSeq = (seqIdx_q == 3'h5);

  always_comb begin
    tLoad = 1'b0;
    tValue = '0;
    // long wait only as the sixth pulse ends, not as it starts
    if (state_q == S_SEQ && lastSeq && !bus_q.chipEnableN && tDone) begin
      tLoad = 1'b1;
      tValue = isRecall_q ? `NVC_CNT_W'(RECALL_CYC) : `NVC_CNT_W'(STORE_CYC);
    end else if ((state_q == S_CYCLE || state_q == S_SEQ) && tDone) begin
      tLoad = 1'b1;
      tValue = `NVC_CNT_W'(`NVC_CYC_CNT);
    end else if (state_q == S_IDLE && hwStoreReq && !reqValid) begin
      tLoad = 1'b1;
      tValue = `NVC_CNT_W'(DELAY_CYC);
    end
  end

  nvc_timer u_timer (
    .clock(clock),
    .reset_n(reset_n),
    .load(tLoad || takeReq),
    .loadValue(takeReq ? `NVC_CNT_W'(`NVC_CYC_CNT) : tValue),
    .done(tDone)
  );

  // power-up recall wait counter, own so the timer stays free
  logic [25:0] purCnt_q;

  // -------------------------------------------------
  // main sequencer
  // -------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= S_POWERUP;
      bus_q <= '{chipEnableN: 1'b1, writeEnableN: 1'b1, outputEnableN: 1'b1, addr: '0};
      seqIdx_q <= 3'h0;
      isWrite_q <= 1'b0;
      isRecall_q <= 1'b0;
      wData_q <= '0;
      reqReady_q <= 1'b0;
      rspValid_q <= 1'b0;
      rspRData_q <= '0;
      dqOe_n_q <= 1'b1;
      busyOe_n_q <= 1'b1;
      purCnt_q <= '0;
    end else begin
      rspValid_q <= 1'b0;
      reqReady_q <= 1'b0;
      case (state_q)
        S_POWERUP: begin
          // controls held inactive so the recall ends outside a write
          purCnt_q <= purCnt_q + 26'h1;
          if (purCnt_q == 26'(PUR_CYC)) begin
            state_q <= S_IDLE;
          end
        end
        S_IDLE: begin
          if (takeReq) begin
            reqReady_q <= 1'b1;
            bus_q.chipEnableN <= 1'b0;
            if (isSeqCmd) begin
              // reads only, write enable high, restart at first address
              seqIdx_q <= 3'h0;
              isRecall_q <= (reqCmd == NVC_CMD_SW_RECALL);
              bus_q.addr <= `NVC_SEQ_A0;
              state_q <= S_SEQ;
            end else begin
              isWrite_q <= (reqCmd == NVC_CMD_WRITE);
              bus_q.addr <= reqAddr;
              bus_q.writeEnableN <= (reqCmd != NVC_CMD_WRITE);
              bus_q.outputEnableN <= (reqCmd == NVC_CMD_WRITE);
              dqOe_n_q <= (reqCmd != NVC_CMD_WRITE);
              wData_q <= reqWData;
              state_q <= S_CYCLE;
            end
          end else if (hwStoreReq && !reqValid) begin
            busyOe_n_q <= 1'b0;
            state_q <= S_HW_DELAY;
          end
        end
        S_CYCLE: begin
          if (tDone) begin
            if (!isWrite_q) begin
              rspValid_q <= 1'b1;
              rspRData_q <= dqIn;
            end
            bus_q.chipEnableN <= 1'b1;
            bus_q.writeEnableN <= 1'b1;
            bus_q.outputEnableN <= 1'b1;
            dqOe_n_q <= 1'b1;
            state_q <= S_GAP;
          end
        end
        S_GAP: begin
          state_q <= S_IDLE;
        end
        S_SEQ: begin
          // CE pulses, each CE low then CE high for NVC_CYC_CNT + 1 cycles, no other access between them
          if (tDone) begin
            if (bus_q.chipEnableN) begin
              bus_q.chipEnableN <= 1'b0;
              bus_q.addr <= seqAddr;
            end else if (lastSeq) begin
              bus_q.chipEnableN <= 1'b1;
              state_q <= S_WAIT_NV;
            end else begin
              bus_q.chipEnableN <= 1'b1;
              seqIdx_q <= seqIdx_q + 3'h1;
            end
          end
        end
        S_WAIT_NV: begin
          if (tDone && !lineLow) begin
            state_q <= S_IDLE;
          end
        end
        S_HW_DELAY: begin
          // device decides during the delay whether a store runs
          if (tDone) begin
            state_q <= S_HW_BUSY;
          end
        end
        S_HW_BUSY: begin
          // device keeps the line low while storing; release then
          busyOe_n_q <= 1'b1;
          state_q <= S_HW_RELEASE;
        end
        S_HW_RELEASE: begin
          if (!lineLow) begin
            state_q <= S_IDLE;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  assign reqReady = reqReady_q;
  assign rspValid = rspValid_q;
  assign rspRData = rspRData_q;
  assign memBus = bus_q;
  assign dqOut = wData_q;
  assign dqOe_n = dqOe_n_q;
  assign busyOe_n = busyOe_n_q;

  // -------------------------------------------------
  // checks
  // -------------------------------------------------
  property p_noWriteInSeq;
    @(posedge clock) disable iff (!reset_n)
      (state_q == S_SEQ) |-> bus_q.writeEnableN;
  endproperty
  a_noWriteInSeq: assert property (p_noWriteInSeq) else $error("write enable low in sequence");

  property p_noWriteLineLow;
    @(posedge clock) disable iff (!reset_n)
      (lineLow && bus_q.writeEnableN) |=> bus_q.writeEnableN;
  endproperty
  a_noWriteLineLow: assert property (p_noWriteLineLow) else $error("write started while line low");

  property p_hwRelease;
    @(posedge clock) disable iff (!reset_n)
      (state_q == S_HW_BUSY) |=> busyOe_n_q;
  endproperty
  a_hwRelease: assert property (p_hwRelease) else $error("request line not released");

  property p_powerupQuiet;
    @(posedge clock) disable iff (!reset_n)
      (state_q == S_POWERUP) |-> (bus_q.chipEnableN && bus_q.writeEnableN);
  endproperty
  a_powerupQuiet: assert property (p_powerupQuiet) else $error("access during power-up recall");

  property p_nvWaitQuiet;
    @(posedge clock) disable iff (!reset_n)
      (state_q == S_WAIT_NV) |-> (bus_q.chipEnableN && dqOe_n_q);
  endproperty
  a_nvWaitQuiet: assert property (p_nvWaitQuiet) else $error("access during nonvolatile cycle");

  property p_hwDelayDrive;
    @(posedge clock) disable iff (!reset_n)
      (state_q == S_HW_DELAY) |-> (!busyOe_n_q && bus_q.chipEnableN);
  endproperty
  a_hwDelayDrive: assert property (p_hwDelayDrive) else $error("request line not held in delay");
endmodule

// ### nvc_dev_model.sv
/*
  Behavioural nvSRAM: SRAM, shadow cells, sequence detector, request/busy.
  Assumes pins synchronous to clock and busyLine resolved with a pull-up.
*/
`timescale 1ns/1ns
module nvc_dev_model
  import nvc_pkg::*;
#(
  parameter int DELAY_CYC = 5,
  parameter int STORE_CYC = 20,
  parameter int RECALL_CYC = 8
)(
  input wire logic clock,
  input nvc_bus_t memBus,
  input wire logic [7:0] dqOut,
  input wire logic dqOe_n,
  input wire logic busyLine,
  output logic [7:0] dqIn = 8'h00,
  output logic devBusyOe_n = 1'b1
);
  logic [7:0] sram [0:8191] = '{default: 8'h00};
  logic [7:0] nv [0:8191] = '{default: 8'h00};
  logic [12:0] seqAddr [0:4] = '{13'h0000, 13'h1555, 13'h0AAA, 13'h1FFF, 13'h10F0};
  logic [12:0] addrQ = 13'h0000;
  logic [7:0] dataQ = 8'h00;
  logic ceLast = 1'b1;
  logic weLast = 1'b1;
  logic dirty = 1'b0;
  int step = 0;
  int busyCnt = 0;
  int hwCnt = 0;
  always @(posedge clock) begin
    ceLast <= memBus.chipEnableN;
    if (!memBus.chipEnableN) begin
      addrQ <= memBus.addr;
      // an undriven data bus reads back inverted, so a missing enable shows up
      dataQ <= dqOe_n ? ~dqOut : dqOut;
      weLast <= memBus.writeEnableN;
    end
    // released bus shows the inverse so stale data cannot pass
    if (!memBus.chipEnableN && !memBus.outputEnableN && busyCnt == 0 && busyLine)
      dqIn <= sram[memBus.addr];
    else
      dqIn <= ~dqIn;
    hwCnt <= busyLine ? 0 : hwCnt + 1;
    if (busyCnt > 0) begin
      busyCnt <= busyCnt - 1;
      if (busyCnt == 1)
        devBusyOe_n <= 1'b1;
    end else if (!busyLine) begin
      if (hwCnt == DELAY_CYC && dirty) begin
        nv = sram;
        dirty <= 1'b0;
        busyCnt <= STORE_CYC;
        devBusyOe_n <= 1'b0;
      end
    end else if (!ceLast && memBus.chipEnableN) begin
      if (!weLast) begin
        sram[addrQ] = dataQ;
        dirty <= 1'b1;
        step <= 0;
      end else if (step == 5 && addrQ == 13'h0F0F) begin
        nv = sram;
        dirty <= 1'b0;
        busyCnt <= STORE_CYC;
        devBusyOe_n <= 1'b0;
        step <= 0;
      end else if (step == 5 && addrQ == 13'h0F0E) begin
        sram = nv;
        dirty <= 1'b0;
        busyCnt <= RECALL_CYC;
        step <= 0;
      end else if (step < 5 && addrQ == seqAddr[step]) begin
        step <= step + 1;
      end else begin
        step <= (addrQ == 13'h0000) ? 1 : 0;
      end
    end
  end
endmodule

// ### test_nvc_host_ctrl.sv
/*
  Self-checking bench for the nvSRAM host controller against nvc_dev_model.
  Assumes the host's four time parameters shortened to 200 ns at a 20 ns clock.
*/
`timescale 1ns/1ns
module test_nvc_host_ctrl;
  import nvc_pkg::*;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic reqValid = 1'b0;
  nvc_cmd_t reqCmd = NVC_CMD_READ;
  logic [12:0] reqAddr = 13'h0000;
  logic [7:0] reqWData = 8'h00;
  logic hwStoreReq = 1'b0;
  logic reqReady, rspValid, dqOe_n, busyOe_n, devBusyOe_n;
  logic [7:0] rspRData, dqOut, dqIn;
  nvc_bus_t memBus;
  wire logic busyLine = busyOe_n & devBusyOe_n;
  int fails = 0;
  int cmp_count = 0;
  int seed = 32'h5fe16cd9;
  logic [7:0] expQ [$];
  logic [12:0] addrs [4] = '{13'h0000, 13'h1FFF, 13'h0AAA, 13'h0F0E};
  logic [7:0] dat [4];
  logic [7:0] kept [4];
  nvc_host_ctrl #(.STORE_NS(200), .RECALL_NS(200), .POWERUP_RECALL_NS(200),
    .DELAY_NS(200)) i_dut (.clock(clock), .reset_n(reset_n), .reqValid(reqValid),
    .reqCmd(reqCmd), .reqAddr(reqAddr), .reqWData(reqWData), .hwStoreReq(hwStoreReq),
    .reqReady(reqReady), .rspValid(rspValid), .rspRData(rspRData), .memBus(memBus),
    .dqOut(dqOut), .dqOe_n(dqOe_n), .dqIn(dqIn), .busyOe_n(busyOe_n),
    .storeRequestBusyLine(busyLine));
  nvc_dev_model i_dev (.clock(clock), .memBus(memBus), .dqOut(dqOut), .dqOe_n(dqOe_n),
    .busyLine(busyLine), .dqIn(dqIn), .devBusyOe_n(devBusyOe_n));
  initial begin
    forever #10 clock = ~clock;
  end
  // -------------------------------------------------
  // tasks
  // -------------------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic access(input nvc_cmd_t cmd, input logic [12:0] a, input logic [7:0] d);
    int n;
    n = 0;
    reqCmd <= cmd;
    reqAddr <= a;
    reqWData <= d;
    reqValid <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (reqReady !== 1'b1 && n < 3000);
    reqValid <= 1'b0;
    if (n >= 3000)
      check(8'h00, 8'hFF);
    repeat (2) @(posedge clock);
  endtask
  task automatic wait_sig(input logic want, input bit host);
    int n;
    n = 0;
    while ((host ? busyOe_n : busyLine) !== want && n < 3000) begin
      @(posedge clock);
      n++;
    end
    if (n >= 3000)
      check(8'h00, 8'hFF);
  endtask
  task automatic rw(input bit rd, input bit rnd);
    for (int i = 0; i < 4; i++) begin
      if (rd) begin
        expQ.push_back(dat[i]);
        access(NVC_CMD_READ, addrs[i], 8'h00);
      end else begin
        if (rnd)
          dat[i] = 8'($random(seed));
        access(NVC_CMD_WRITE, addrs[i], dat[i]);
      end
    end
  endtask
  task automatic report_and_stop();
    if (fails == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // -------------------------------------------------
  // read result scoreboard
  // -------------------------------------------------
  always @(posedge clock) begin
    if (rspValid === 1'b1)
      check(rspRData, expQ.size() > 0 ? expQ.pop_front() : 8'hXX);
  end
  // whole run is well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    rw(0, 1);
    rw(1, 0);
    access(NVC_CMD_SW_STORE, 13'h0000, 8'h00);
    kept = dat;
    rw(0, 1);
    access(NVC_CMD_SW_RECALL, 13'h0000, 8'h00);
    dat = kept;
    rw(1, 0);
    rw(0, 1);
    hwStoreReq <= 1'b1;
    wait_sig(1'b0, 1);
    hwStoreReq <= 1'b0;
    wait_sig(1'b1, 1);
    check({7'h00, busyLine}, 8'h00);
    wait_sig(1'b1, 0);
    kept = dat;
    rw(0, 1);
    access(NVC_CMD_SW_RECALL, 13'h0000, 8'h00);
    dat = kept;
    rw(1, 0);
    hwStoreReq <= 1'b1;
    wait_sig(1'b0, 1);
    hwStoreReq <= 1'b0;
    wait_sig(1'b1, 1);
    @(posedge clock);
    check({7'h00, busyLine}, 8'h01);
    rw(1, 0);
    repeat (20) @(posedge clock);
    check(8'(expQ.size()), 8'h00);
    report_and_stop();
  end
endmodule
